// *** design/flag_cell.sv ***
// one sticky status flag, hardware set wins over software clear
`timescale 1ns/100ps
module flag_cell (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic set_pulse,
    input wire logic wr_en,
    input wire logic wr_val,
    output logic flag_q
);
    logic flag_d; // next flag value
    // set beats clear; a write of 1 also stores 1
    assign flag_d = set_pulse ? 1'b1 : (wr_en ? wr_val : flag_q);
    ///////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule : flag_cell

// *** design/reset_cause_status_control.sv ***
// reset cause and control register with sticky event flags
`timescale 1ns/100ps
`include "rcon_consts.svh"
module reset_cause_status_control (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`RC_ADDR_W-1:0] addr,
    input wire rcon_pkg::word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output rcon_pkg::word_t rdata,
    input wire logic evt_trap_conflict,
    input wire logic evt_illegal_operation,
    input wire logic evt_deep_sleep,
    input wire logic evt_master_clear_pin,
    input wire logic evt_reset_instruction,
    input wire logic evt_watchdog_timeout,
    input wire logic evt_sleep,
    input wire logic evt_idle,
    output logic brownout_reset_enable,
    output logic watchdog_timer_enable,
    output logic progmem_sleep_power
);
    import rcon_pkg::*;
    ///////////////////////////////////////////////////////////////////
    // register map of the single word at the mapped address
    //   bit 15  trap conflict reset flag, sticky
    //   bit 14  illegal operation reset flag, sticky
    //   bit 13  soft brownout enable, control
    //   bit 12  unimplemented, reads zero
    //   bit 11  unimplemented, reads zero
    //   bit 10  deep sleep flag, sticky
    //   bit 9   unimplemented, reads zero
    //   bit 8   progmem sleep power, control
    //   bit 7   external pin reset flag, sticky
    //   bit 6   software reset flag, sticky
    //   bit 5   soft watchdog enable, control
    //   bit 4   watchdog timeout flag, sticky
    //   bit 3   sleep wake flag, sticky
    //   bit 2   idle flag, sticky
    //   bit 1   unimplemented, reads zero
    //   bit 0   unimplemented, reads zero
    // sticky flags: an event sets, software writes 0 to clear
    // a write of 1 to a flag also sets it, so saved words restore
    // an event in the cycle of a clearing write wins
    // controls: plain read/write bits, cleared by reset
    // other addresses: writes dropped, reads return zero
    ///////////////////////////////////////////////////////////////////
    // decode helpers
    // address selects the register word
    function automatic logic reg_match(input logic [`RC_ADDR_W-1:0] a);
        reg_match = (a == `RC_REG_ADDR);
    endfunction : reg_match
    // bit holds a sticky status flag
    function automatic logic is_flag_bit(input logic [3:0] b);
        word_t m; // flag mask
        m = `RC_FLAG_MASK;
        is_flag_bit = m[b];
    endfunction : is_flag_bit
    // bit holds a software control
    function automatic logic is_ctrl_bit(input logic [3:0] b);
        word_t m; // control mask
        m = `RC_CTRL_MASK;
        is_ctrl_bit = m[b];
    endfunction : is_ctrl_bit
    ///////////////////////////////////////////////////////////////////
    // decode
    logic hit; // address matches the register
    logic wr_hit; // write to the register
    logic rd_hit; // read of the register
    assign hit = reg_match(addr);
    assign wr_hit = wr_stb & hit;
    assign rd_hit = rd_stb & hit;
    ///////////////////////////////////////////////////////////////////
    // flags
    evt_vec_t evt; // event strobes in flag order
    evt_vec_t flag_q; // sticky flags
    word_t flags_w; // flags placed at their bit positions
    logic [3:0] pos [0:`RC_N_EVT-1]; // bit position of each flag
    assign evt = {evt_trap_conflict, evt_illegal_operation, evt_deep_sleep,
                  evt_master_clear_pin, evt_reset_instruction, evt_watchdog_timeout,
                  evt_sleep, evt_idle, 1'b0};
    assign pos[0] = 4'(`RC_BIT_TRAP);
    assign pos[1] = 4'(`RC_BIT_IOPU);
    assign pos[2] = 4'(`RC_BIT_DSLP);
    assign pos[3] = 4'(`RC_BIT_EXT);
    assign pos[4] = 4'(`RC_BIT_SWRST);
    assign pos[5] = 4'(`RC_BIT_WD_TIMEOUT);
    assign pos[6] = 4'(`RC_BIT_SLEEP);
    assign pos[7] = 4'(`RC_BIT_IDLE);
    assign pos[8] = 4'h0; // spare slot, unused
    // one sticky cell per flag
    genvar gi;
    generate
        for (gi = 0; gi < `RC_N_EVT - 1; gi++) begin : g_flag
            flag_cell u_cell (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .set_pulse(evt[`RC_N_EVT-1-gi]),
                .wr_en(wr_hit),
                .wr_val(wdata[pos[gi]]),
                .flag_q(flag_q[gi])
            );
        end
    endgenerate
    assign flag_q[8] = 1'b0;
    // place flags into the word
    always_comb begin
        flags_w = 16'h0000;
        for (int i = 0; i < `RC_N_EVT - 1; i++) begin
            flags_w[pos[i]] = flag_q[i];
        end
    end
    ///////////////////////////////////////////////////////////////////
    // software controls
    word_t ctrl_q; // control bits
    word_t ctrl_d; // next control bits
    assign ctrl_d = wr_hit ? (wdata & `RC_CTRL_MASK) : ctrl_q;
    // control register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `RC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign brownout_reset_enable = ctrl_q[`RC_BIT_BOREN];
    assign watchdog_timer_enable = ctrl_q[`RC_BIT_WDEN];
    assign progmem_sleep_power = ctrl_q[`RC_BIT_PM_POWER];
    ///////////////////////////////////////////////////////////////////
    // read back, unimplemented bits zero, data one cycle later
    word_t rd_word; // word for a hit
    word_t rdata_d; // next read data
    genvar gb;
    // one read source per bit: sticky flag, control bit or zero
    generate
        for (gb = 0; gb < 16; gb++) begin : g_rbit
            assign rd_word[gb] = (is_flag_bit(4'(gb)) & flags_w[gb]) | (is_ctrl_bit(4'(gb)) & ctrl_q[gb]);
        end
    endgenerate
    assign rdata_d = rd_hit ? rd_word : 16'h0000;
    // read data register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_d;
        end
    end
endmodule : reset_cause_status_control

// *** pkg/rcon_consts.svh ***
// offsets, field positions, masks, reset values and event count of the reset cause register
// Notes on behaviour
// - trap conflict reset sets bit 15
// - illegal opcode or pointer sets bit 14
// - bit 13 enables brownout reset circuit
// - bits 12, 11, 9 read zero
// - deep sleep sets bit 10
// - bit 8 keeps progmem bias powered in sleep
// - master clear pin reset sets bit 7
// - reset instruction sets bit 6
// - bit 5 enables the watchdog timer
// - watchdog time-out sets bit 4
// - sleep entry sets bit 3
// - idle entry sets the idle flag
`ifndef RCON_CONSTS_SVH
`define RCON_CONSTS_SVH
`define RC_ADDR_W 4
`define RC_REG_ADDR 4'h0
`define RC_BIT_TRAP 15
`define RC_BIT_IOPU 14
`define RC_BIT_BOREN 13
`define RC_BIT_DSLP 10
`define RC_BIT_PM_POWER 8
`define RC_BIT_EXT 7
`define RC_BIT_SWRST 6
`define RC_BIT_WDEN 5
`define RC_BIT_WD_TIMEOUT 4
`define RC_BIT_SLEEP 3
`define RC_BIT_IDLE 2
`define RC_FLAG_MASK 16'hC4DC
`define RC_CTRL_MASK 16'h2120
`define RC_CTRL_RESET 16'h0000
`define RC_N_EVT 9
`endif

// *** pkg/rcon_pkg.sv ***
// types shared by the reset cause register files
package rcon_pkg;
    // one event strobe per flag
    typedef logic [8:0] evt_vec_t;
    // register word
    typedef logic [15:0] word_t;
    // software access kind
    typedef enum logic [1:0] {
        acc_idle = 2'b00,
        acc_write = 2'b01,
        acc_read = 2'b10
    } acc_t;
endpackage : rcon_pkg

// *** tb/rcon_sva.sv ***
// checker for the reset cause register ports
`timescale 1ns/100ps
module rcon_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire rcon_pkg::word_t wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire rcon_pkg::word_t rdata,
    input wire logic evt_trap_conflict,
    input wire logic evt_illegal_operation,
    input wire logic evt_deep_sleep,
    input wire logic evt_master_clear_pin,
    input wire logic evt_reset_instruction,
    input wire logic evt_watchdog_timeout,
    input wire logic evt_sleep,
    input wire logic evt_idle,
    input wire logic brownout_reset_enable,
    input wire logic watchdog_timer_enable,
    input wire logic progmem_sleep_power
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence rd0; rd_stb && addr == 4'h0; endsequence
    sequence wr0; wr_stb && addr == 4'h0; endsequence
    AST_TRAP: assert property (evt_trap_conflict ##1 rd0 |=> rdata[15]) else $error("trap flag");
    AST_ILLEGAL: assert property (evt_illegal_operation ##1 rd0 |=> rdata[14]) else $error("illegal flag");
    AST_DEEP: assert property (evt_deep_sleep ##1 rd0 |=> rdata[10]) else $error("deep sleep flag");
    AST_EXT: assert property (evt_master_clear_pin ##1 rd0 |=> rdata[7]) else $error("pin flag");
    AST_SOFT_RESET: assert property (evt_reset_instruction ##1 rd0 |=> rdata[6]) else $error("soft reset flag");
    AST_WD_TIMEOUT: assert property (evt_watchdog_timeout ##1 rd0 |=> rdata[4]) else $error("timeout flag");
    AST_SLP: assert property (evt_sleep ##1 rd0 |=> rdata[3]) else $error("sleep flag");
    AST_IDLE: assert property (evt_idle ##1 rd0 |=> rdata[2]) else $error("idle flag");
    AST_GAP: assert property (rd0 |=> rdata[12:11] == 2'h0 && !rdata[9]) else $error("unused bits");
    AST_RD_IDLE: assert property (!(rd_stb && addr == 4'h0) |=> rdata == 16'h0000) else $error("idle data");
    AST_BO_EN: assert property (wr0 |=> brownout_reset_enable == $past(wdata[13])) else $error("brownout en");
    AST_PM: assert property (wr0 |=> progmem_sleep_power == $past(wdata[8])) else $error("pm");
    AST_WDEN: assert property (wr0 |=> watchdog_timer_enable == $past(wdata[5])) else $error("watchdog en");
endmodule : rcon_sva
bind reset_cause_status_control rcon_sva chk (.*);

// *** tb/reset_cause_status_control_tb.sv ***
// self-checking bench for the reset cause register
`timescale 1ns/100ps
module reset_cause_status_control_tb;
    import rcon_pkg::*;
    logic clk_sys = 0, rstn = 0, wr_stb = 0, rd_stb = 0, bo_en, wd_en, pm;
    logic [3:0] addr = 4'h0;
    word_t wdata = 16'h0000, rdata, acc;
    logic [7:0] ev = 8'h00;
    int mismatches = 0, cmp_count = 0;
    int pos [8] = '{15, 14, 10, 7, 6, 4, 3, 2};
    always #10 clk_sys = ~clk_sys;
    reset_cause_status_control dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .evt_trap_conflict(ev[0]), .evt_illegal_operation(ev[1]),
        .evt_deep_sleep(ev[2]), .evt_master_clear_pin(ev[3]), .evt_reset_instruction(ev[4]),
        .evt_watchdog_timeout(ev[5]), .evt_sleep(ev[6]), .evt_idle(ev[7]), .brownout_reset_enable(bo_en),
        .watchdog_timer_enable(wd_en), .progmem_sleep_power(pm));
    task chk(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input word_t d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [3:0] a, input word_t exp);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    task t_ctrl;
        rd(4'h0, 16'h0000);
        wr(4'h0, 16'h2000);
        chk({13'h0000, bo_en, wd_en, pm}, 16'h0004);
        wr(4'h0, 16'h0020);
        chk({13'h0000, bo_en, wd_en, pm}, 16'h0002);
        wr(4'h0, 16'hFFFF);
        chk({13'h0000, bo_en, wd_en, pm}, 16'h0007);
        rd(4'h0, 16'hE5FC);
        wr(4'h5, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h0, 16'hE5FC);
        wr(4'h0, 16'h0000);
        chk({13'h0000, bo_en, wd_en, pm}, 16'h0000);
    endtask : t_ctrl
    task t_flags;
        acc = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            ev <= 8'h01 << i;
            @(posedge clk_sys);
            ev <= 8'h00;
            addr <= 4'h0;
            rd_stb <= 1'b1;
            @(posedge clk_sys);
            rd_stb <= 1'b0;
            acc = acc | (16'h0001 << pos[i]);
            #1 chk(rdata, acc);
        end
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0000);
        @(posedge clk_sys);
        ev <= 8'h01;
        wdata <= 16'h0000;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        ev <= 8'h00;
        wr_stb <= 1'b0;
        rd(4'h0, 16'h8000);
    endtask : t_flags
    task t_reset;
        wr(4'h0, 16'hFFFF);
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        #1 chk({13'h0000, bo_en, wd_en, pm}, 16'h0000);
        chk(rdata, 16'h0000);
        @(posedge clk_sys);
        rstn <= 1'b1;
        rd(4'h0, 16'h0000);
    endtask : t_reset
    task print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        t_ctrl;
        t_flags;
        t_reset;
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        print_verdict;
    end
endmodule : reset_cause_status_control_tb
